/* File: logic/mdmsf_defs.vh */
`ifndef MDMSF_DEFS_VH
`define MDMSF_DEFS_VH
// register addresses
`define MDMSF_ADDR_STATUS2 6'h08
`define MDMSF_ADDR_QUEUE_PORT_BYTE 6'h09
`define MDMSF_ADDR_LEVEL 6'h0A
// status two fields
`define MDMSF_S2_TCLR 7
`define MDMSF_S2_HSF 6
`define MDMSF_S2_LSEL 4
`define MDMSF_S2_CIPH 3
`define MDMSF_S2_RESET 8'h00
// level register fields
`define MDMSF_LVL_FLUSH 7
// transceiver phase codes
`define MDMSF_PH_IDLE 3'h0
`define MDMSF_PH_WSTART 3'h1
`define MDMSF_PH_TXWAIT 3'h2
`define MDMSF_PH_SEND 3'h3
`define MDMSF_PH_RX_GUARD_TIME 3'h4
`define MDMSF_PH_WDATA 3'h5
`define MDMSF_PH_RECV 3'h6
`endif

/* File: logic/mdmsf_queue.v */
`timescale 1ns/10ps
// byte queue: discards push when full, pop when empty holds pointers
module mdmsf_queue #(
  parameter DEPTH = 64,
  parameter AW = 6
) (
  // clocking
  input wire core_clk,
  input wire rst,
  input wire clkEn,
  // control
  input wire flush,
  input wire push,
  input wire [7:0] pushData,
  input wire pop,
  // status
  output wire [7:0] headData,
  output wire [AW:0] fillCount,
  output wire full,
  output wire empty,
  output reg overflow_ff
);
  reg [7:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire doPush;
  wire doPop;
  assign full = (count_ff == DEPTH[AW:0]);
  assign empty = (count_ff == {(AW+1){1'b0}});
  assign doPush = push & ~full;
  assign doPop = pop & ~empty;
  assign headData = mem[rdPtr_ff];
  assign fillCount = count_ff;
  always @(posedge core_clk) begin
    if (clkEn && doPush && !flush) begin
      mem[wrPtr_ff] <= pushData;
    end
  end
  always @(posedge core_clk) begin
    if (rst) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      overflow_ff <= 1'b0;
    end else if (clkEn) begin
      if (flush) begin
        wrPtr_ff <= {AW{1'b0}};
        rdPtr_ff <= {AW{1'b0}};
        count_ff <= {(AW+1){1'b0}};
        overflow_ff <= 1'b0;
      end else begin
        if (doPush) begin
          wrPtr_ff <= wrPtr_ff + 1'b1;
        end
        if (doPop) begin
          rdPtr_ff <= rdPtr_ff + 1'b1;
        end
        if (doPush && !doPop) begin
          count_ff <= count_ff + 1'b1;
        end else if (doPop && !doPush) begin
          count_ff <= count_ff - 1'b1;
        end
        if (push && full) begin
          overflow_ff <= 1'b1;
        end
      end
    end
  end
endmodule // mdmsf_queue

/* File: logic/mdmsf_status_fifo.v */
`timescale 1ns/10ps
`include "mdmsf_defs.vh"
// Overview of operation
// - writing thermal clear drops temp error only below 125 C limit.
// - force bit selects high-speed host input filter; else follows protocol.
// - listen-side flag sets after answering select or polling as target.
// - listen-side flag sets only during passive auto anticollision.
// - listen-side flag clears when external RF field disappears.
// - cipher flag enables encryption of all card data.
// - cipher flag sets only on successful cipher authentication.
// - phase field reports idle, sending, wait-data, receiving codes.
// - phase 001 while waiting for launch-transmit bit.
// - phase 010 waits tx guard time and optionally RF field.
// - phase 100 waits rx guard time and optionally RF field.
// - data port writes push, reads pop oldest of 64 bytes.
// - queue buffers bytes for all serial transmit/receive streams.
// - write increments stored count, read decrements it.
// - flush resets pointers and overflow flag; flush reads zero.
module mdmsf_status_fifo #(
  parameter DEPTH = 64,
  parameter AW = 6,
  parameter GW = 8
) (
  // clocking
  input wire core_clk,
  input wire rst,
  input wire clkEn,
  // register port
  input wire [5:0] regAddr,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData_ff,
  // temperature
  input wire tempAboveLimit,
  input wire tempErrSet,
  output reg tempErr_ff,
  // host filter
  input wire hostHsProtocol,
  output wire hsFilterOn,
  // command and field events
  input wire autoAnticollActive,
  input wire passiveMode,
  input wire targetAnswered,
  input wire rfFieldPresent,
  input wire cipherAuthOk,
  output wire cipherEncrypt,
  // transceive sequencing
  input wire transceiveStart,
  input wire launchTransmit,
  input wire txHoldForField,
  input wire rxHoldForField,
  input wire [GW-1:0] txGuardCycles,
  input wire [GW-1:0] rxGuardCycles,
  input wire rxFrameStart,
  input wire rxFrameEnd,
  input wire abortSeq,
  // serial side of queue
  output wire [7:0] txByte,
  output wire txByteValid,
  input wire txByteTake,
  input wire [7:0] rxByte,
  input wire rxByteValid,
  output wire sending,
  input wire sendDone,
  // status
  output wire [AW:0] queueFillCount,
  output wire queueOverflowFlag
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_WSTART = 7'h02;
  localparam [6:0] ST_TXWAIT = 7'h04;
  localparam [6:0] ST_SEND = 7'h08;
  localparam [6:0] ST_RX_GUARD_TIME = 7'h10;
  localparam [6:0] ST_WDATA = 7'h20;
  localparam [6:0] ST_RECV = 7'h40;

  reg [6:0] state_ff;
  reg [6:0] nxt_state;
  reg [GW-1:0] guard_ff;
  reg [GW-1:0] nxt_guard;
  reg hsForce_ff;
  reg listenSel_ff;
  reg cipher_ff;
  reg [2:0] phase;
  wire wrS2;
  wire wrLvl;
  wire rdData;
  wire wrData;
  wire flush;
  wire qFull;
  wire qEmpty;
  wire [7:0] qHead;
  wire qPush;
  wire qPop;
  wire [7:0] qPushData;

  function hit;
    input [5:0] a;
    input [5:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign wrS2 = regWr & hit(regAddr, `MDMSF_ADDR_STATUS2);
  assign wrLvl = regWr & hit(regAddr, `MDMSF_ADDR_LEVEL);
  assign wrData = regWr & hit(regAddr, `MDMSF_ADDR_QUEUE_PORT_BYTE);
  assign rdData = regRd & hit(regAddr, `MDMSF_ADDR_QUEUE_PORT_BYTE);
  assign flush = wrLvl & regWrData[`MDMSF_LVL_FLUSH];

  assign hsFilterOn = hsForce_ff | hostHsProtocol;
  assign cipherEncrypt = cipher_ff;

  assign sending = state_ff[3];
  assign qPush = wrData | (state_ff[6] & rxByteValid);
  assign qPushData = wrData ? regWrData : rxByte;
  assign qPop = rdData | (state_ff[3] & txByteTake);
  assign txByte = qHead;
  assign txByteValid = state_ff[3] & ~qEmpty;

  mdmsf_queue #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) uQueue (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .flush(flush),
    .push(qPush),
    .pushData(qPushData),
    .pop(qPop),
    .headData(qHead),
    .fillCount(queueFillCount),
    .full(qFull),
    .empty(qEmpty),
    .overflow_ff(queueOverflowFlag)
  );

  always @* begin
    nxt_state = state_ff;
    nxt_guard = guard_ff;
    if (guard_ff != {GW{1'b0}}) begin
      nxt_guard = guard_ff - 1'b1;
    end
    case (state_ff)
      ST_IDLE: begin
        if (transceiveStart) begin
          nxt_state = ST_WSTART;
        end
      end
      ST_WSTART: begin
        if (launchTransmit) begin
          nxt_state = ST_TXWAIT;
          nxt_guard = txGuardCycles;
        end
      end
      ST_TXWAIT: begin
        if (guard_ff == {GW{1'b0}} && (!txHoldForField || rfFieldPresent)) begin
          nxt_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (sendDone) begin
          nxt_state = ST_RX_GUARD_TIME;
          nxt_guard = rxGuardCycles;
        end
      end
      ST_RX_GUARD_TIME: begin
        if (guard_ff == {GW{1'b0}} && (!rxHoldForField || rfFieldPresent)) begin
          nxt_state = ST_WDATA;
        end
      end
      ST_WDATA: begin
        if (rxFrameStart) begin
          nxt_state = ST_RECV;
        end
      end
      ST_RECV: begin
        if (rxFrameEnd) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (abortSeq) begin
      nxt_state = ST_IDLE;
    end
  end

  always @* begin
    case (state_ff)
      ST_WSTART: phase = `MDMSF_PH_WSTART;
      ST_TXWAIT: phase = `MDMSF_PH_TXWAIT;
      ST_SEND: phase = `MDMSF_PH_SEND;
      ST_RX_GUARD_TIME: phase = `MDMSF_PH_RX_GUARD_TIME;
      ST_WDATA: phase = `MDMSF_PH_WDATA;
      ST_RECV: phase = `MDMSF_PH_RECV;
      default: phase = `MDMSF_PH_IDLE;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      guard_ff <= {GW{1'b0}};
      hsForce_ff <= 1'b0;
      listenSel_ff <= 1'b0;
      cipher_ff <= 1'b0;
      tempErr_ff <= 1'b0;
      regRdData_ff <= 8'h00;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      guard_ff <= nxt_guard;
      if (wrS2) begin
        hsForce_ff <= regWrData[`MDMSF_S2_HSF];
      end
      // clear only when cool; set wins
      if (tempErrSet) begin
        tempErr_ff <= 1'b1;
      end else if (wrS2 && regWrData[`MDMSF_S2_TCLR] && !tempAboveLimit) begin
        tempErr_ff <= 1'b0;
      end
      if (!rfFieldPresent) begin
        listenSel_ff <= 1'b0;
      end else if (targetAnswered && autoAnticollActive && passiveMode) begin
        listenSel_ff <= 1'b1;
      end
      if (cipherAuthOk) begin
        cipher_ff <= 1'b1;
      end else if (wrS2 && !regWrData[`MDMSF_S2_CIPH]) begin
        cipher_ff <= 1'b0;
      end
      if (regRd) begin
        case (regAddr)
          `MDMSF_ADDR_STATUS2: regRdData_ff <= {1'b0, hsForce_ff, 1'b0,
            listenSel_ff, cipher_ff, phase};
          `MDMSF_ADDR_QUEUE_PORT_BYTE: regRdData_ff <= qHead;
          `MDMSF_ADDR_LEVEL: regRdData_ff <= {1'b0, queueFillCount[6:0]};
          default: regRdData_ff <= 8'h00;
        endcase
      end
    end
  end
endmodule // mdmsf_status_fifo

/* File: verification/mdmsf_host.sv */
`timescale 1ns/10ps
// host model: one strobe per access, held to the taking edge
module mdmsf_host (
  // clocking
  input wire core_clk,
  // register port
  output reg [5:0] regAddr = 6'h00,
  output reg regWr = 1'b0,
  output reg regRd = 1'b0,
  output reg [7:0] regWrData = 8'h00,
  input wire [7:0] regRdData_ff
);
  task wr(input [5:0] a, input [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  // answer lands on the taking edge and is read one edge later
  task rd(input [5:0] a, output [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
    d = regRdData_ff;
  endtask
endmodule // mdmsf_host

/* File: verification/mdmsf_status_fifo_properties.sv */
`timescale 1ns/10ps
module mdmsf_status_fifo_properties #(
  parameter DEPTH = 64,
  parameter AW = 6
) (
  // clocking
  input wire core_clk,
  input wire rst,
  // register port
  input wire [5:0] regAddr,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData_ff,
  // status and events
  input wire tempAboveLimit,
  input wire rfFieldPresent,
  input wire txHoldForField,
  input wire tempErr_ff,
  input wire hostHsProtocol,
  input wire hsFilterOn,
  input wire cipherAuthOk,
  input wire cipherEncrypt,
  input wire sending,
  input wire txByteValid,
  input wire txByteTake,
  input wire rxByteValid,
  input wire [AW:0] queueFillCount,
  input wire queueOverflowFlag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // serial side idle, so host access alone moves the count
  wire quiet = !rxByteValid && !txByteTake;
  sequence push_s; regWr && regAddr == 6'h09 && quiet; endsequence
  sequence pop_s; regRd && regAddr == 6'h09 && quiet; endsequence
  hs_filter_a: assert property (hostHsProtocol |-> hsFilterOn)
    else $error("filter off under protocol");
  fill_up_a: assert property (push_s ##0 queueFillCount < DEPTH
    |=> queueFillCount == $past(queueFillCount) + 1) else $error("no inc");
  fill_down_a: assert property (pop_s ##0 queueFillCount != 0
    |=> queueFillCount == $past(queueFillCount) - 1) else $error("no dec");
  full_drop_a: assert property (push_s ##0 queueFillCount == DEPTH
    |=> queueOverflowFlag && queueFillCount == DEPTH) else $error("full");
  empty_hold_a: assert property (pop_s ##0 queueFillCount == 0
    |=> queueFillCount == 0) else $error("empty pop moved count");
  flush_all_a: assert property (regWr && regAddr == 6'h0A &&
    regWrData[7] |=> queueFillCount == 0 && !queueOverflowFlag)
    else $error("flush incomplete");
  reserved_zero_a: assert property (regRd && regAddr == 6'h08
    |=> !regRdData_ff[5] && !regRdData_ff[7]) else $error("bit set");
  phase_send_a: assert property (regRd && regAddr == 6'h08
    |=> (regRdData_ff[2:0] == 3'h3) == $past(sending))
    else $error("phase and sending differ");
  cipher_set_a: assert property ($rose(cipherEncrypt)
    |-> $past(cipherAuthOk)) else $error("cipher set without auth");
  temp_clear_a: assert property (!$past(rst) && $fell(tempErr_ff)
    |-> !$past(tempAboveLimit)) else $error("temp cleared while hot");
  tx_valid_a: assert property (sending
    |-> txByteValid == (queueFillCount != 0)) else $error("tx valid");
  tx_field_a: assert property ($rose(sending)
    && $past(txHoldForField) |-> $past(rfFieldPresent))
    else $error("sent without field");
endmodule // mdmsf_status_fifo_properties
bind mdmsf_status_fifo mdmsf_status_fifo_properties #(.DEPTH(DEPTH),
  .AW(AW)) chk (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
  .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
  .regRdData_ff(regRdData_ff), .tempAboveLimit(tempAboveLimit),
  .rfFieldPresent(rfFieldPresent), .txHoldForField(txHoldForField),
  .tempErr_ff(tempErr_ff), .hostHsProtocol(hostHsProtocol),
  .hsFilterOn(hsFilterOn), .cipherAuthOk(cipherAuthOk),
  .cipherEncrypt(cipherEncrypt), .sending(sending),
  .txByteValid(txByteValid), .txByteTake(txByteTake),
  .rxByteValid(rxByteValid), .queueFillCount(queueFillCount),
  .queueOverflowFlag(queueOverflowFlag));

/* File: verification/mdmsf_status_fifo_tb.sv */
`timescale 1ns/10ps
`define CK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module mdmsf_status_fifo_tb;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [16:0] iv = 17'h00040;
  reg [7:0] rxb = 8'h00;
  reg [7:0] g = 8'h20;
  reg [16:0] r = 17'h18370;
  reg [7:0] st;
  reg [7:0] q[$];
  int error_cnt = 0, check_count = 0, hsf = 0, ls = 0, cp = 0, i;
  wire [5:0] regAddr;
  wire regWr, regRd, tErr, hsOn, enc, txV, snd, ovf;
  wire [7:0] regWrData, regRdData_ff, txByte;
  wire [6:0] fill;
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  mdmsf_host H (.core_clk(core_clk), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWrData(regWrData), .regRdData_ff(regRdData_ff));
  mdmsf_status_fifo DUT (.core_clk(core_clk), .rst(rst), .clkEn(1'b1),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
    .regRdData_ff(regRdData_ff), .tempAboveLimit(iv[0]), .tempErrSet(iv[1]),
    .tempErr_ff(tErr), .hostHsProtocol(iv[2]), .hsFilterOn(hsOn),
    .autoAnticollActive(iv[3]), .passiveMode(iv[4]), .targetAnswered(iv[5]),
    .rfFieldPresent(iv[6]), .cipherAuthOk(iv[7]), .cipherEncrypt(enc),
    .transceiveStart(iv[8]), .launchTransmit(iv[9]), .txHoldForField(iv[14]),
    .rxHoldForField(iv[15]), .txGuardCycles(g), .rxGuardCycles(g),
    .rxFrameStart(iv[10]), .rxFrameEnd(iv[11]), .abortSeq(1'b0),
    .txByte(txByte), .txByteValid(txV), .txByteTake(iv[16]), .rxByte(rxb),
    .rxByteValid(iv[12]), .sending(snd), .sendDone(iv[13]),
    .queueFillCount(fill), .queueOverflowFlag(ovf));
  function [16:0] lf(input [16:0] s);
    lf = {s[15:0], s[16] ^ s[13]};
  endfunction
  function [7:0] s2(input [2:0] ph);
    s2 = {1'b0, hsf[0], 1'b0, ls[0], cp[0], ph};
  endfunction
  task p(input int b);
    @(posedge core_clk);
    iv[b] <= 1'b1;
    @(posedge core_clk);
    iv[b] <= 1'b0;
  endtask
  task rc(input [5:0] a, input [7:0] e);
    H.rd(a, st);
    `CK("reg", e, st)
  endtask
  task stop_test;
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // poll phase; a stuck sequencer ends the run
  task wp(input [2:0] ph);
    st = 8'hFF;
    for (i = 0; i < 40 && st[2:0] !== ph; i++) H.rd(6'h08, st);
    `CK("phase", ph, st[2:0])
    if (st[2:0] !== ph) stop_test;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rc(6'h08, 8'h00);
    rc(6'h0A, 8'h00);
    iv[2] <= 1'b1;
    @(posedge core_clk);
    `CK("hs", 1'b1, hsOn)
    iv[2] <= 1'b0;
    @(posedge core_clk);
    `CK("hs", 1'b0, hsOn)
    H.wr(6'h08, 8'h40);
    hsf = 1;
    rc(6'h08, s2(0));
    `CK("hs", 1'b1, hsOn)
    iv[0] <= 1'b1;
    p(1);
    H.wr(6'h08, 8'hC0);
    rc(6'h08, s2(0));
    `CK("temp", 1'b1, tErr)
    iv[0] <= 1'b0;
    H.wr(6'h08, 8'hC0);
    rc(6'h08, s2(0));
    `CK("temp", 1'b0, tErr)
    iv[3] <= 1'b1;
    p(5);
    rc(6'h08, s2(0));
    iv[4] <= 1'b1;
    p(5);
    ls = 1;
    rc(6'h08, s2(0));
    iv[6] <= 1'b0;
    ls = 0;
    rc(6'h08, s2(0));
    iv[6] <= 1'b1;
    H.wr(6'h08, 8'h48);
    rc(6'h08, s2(0));
    p(7);
    cp = 1;
    rc(6'h08, s2(0));
    `CK("enc", 1'b1, enc)
    // host ends the session itself
    H.wr(6'h08, 8'h40);
    cp = 0;
    rc(6'h08, s2(0));
    for (i = 0; i < 65; i++) begin
      r = lf(r);
      H.wr(6'h09, r[7:0]);
      if (q.size() < 64) q.push_back(r[7:0]);
    end
    rc(6'h0A, 8'h40);
    `CK("fill", 7'h40, fill)
    `CK("ovf", 1'b1, ovf)
    for (i = 0; i < 3; i++) rc(6'h09, q.pop_front());
    rc(6'h0A, 8'h3D);
    H.wr(6'h0A, 8'h80);
    q.delete();
    rc(6'h0A, 8'h00);
    `CK("ovf", 1'b0, ovf)
    H.rd(6'h09, st);
    rc(6'h0A, 8'h00);
    H.wr(6'h09, 8'h5A);
    q.push_back(8'h5A);
    // short random guard; field kept off so the wait outlasts it
    r = lf(r);
    g <= {4'h0, 1'b1, r[2:0]};
    iv[15:14] <= 2'b11;
    iv[6] <= 1'b0;
    p(8);
    wp(1);
    p(9);
    wp(2);
    repeat (20) @(posedge core_clk);
    wp(2);
    iv[6] <= 1'b1;
    wp(3);
    `CK("snd", 1'b1, snd)
    `CK("txv", 1'b1, txV)
    `CK("txb", 8'h5A, txByte)
    p(16);
    void'(q.pop_front());
    @(posedge core_clk);
    `CK("txv", 1'b0, txV)
    iv[6] <= 1'b0;
    p(13);
    wp(4);
    repeat (20) @(posedge core_clk);
    wp(4);
    `CK("snd", 1'b0, snd)
    iv[6] <= 1'b1;
    wp(5);
    p(10);
    wp(6);
    r = lf(r);
    rxb <= r[7:0];
    p(12);
    q.push_back(r[7:0]);
    p(11);
    wp(0);
    while (q.size() > 0) rc(6'h09, q.pop_front());
    stop_test;
  end
endmodule // mdmsf_status_fifo_tb
